// ===== common/rsi_pkg.sv
// constants for the reset source and initialization control block
// Overview of operation
// - seven init sources ranked: por, alternate pin, bus reset, bus_n_a, d3-to-d0, soft, selective
// - software reset targets also hit by d3-to-d0, alternate and bus reset
// - eeprom autoload only after por, alternate, bus reset or bus_n_a
// - mac config, multicast hash, microcode reset by all but selective reset
// - pme state cleared by por/alternate; bus reset/bus_n_a only without aux power
// - config pins sampled only on por, alternate or bus reset
// - alternate, bus reset, bus_n_a end mgmt transaction, force status and rx inactive
// - aborted mgmt read by d3-d0/soft/selective returns zeros until cycle ends
// - aborted mgmt write by d3-d0/soft/selective changes no state
// - after d3-to-d0 assert mgmt alert output
// - after d3-to-d0 set init bit in mgmt status word
// - soft/selective reset report init like d3-d0, leave status and rx enable
// - bus_n_a acts as reset on its deasserting edge
// - in d3, bus reset initializes on its trailing edge
// - mgmt alert is open-drain active low
package rsi_pkg;
    // register offsets (byte addresses)
    localparam logic [3:0] RSI_OFS_STATUS = 4'h0;
    localparam logic [3:0] RSI_OFS_ENABLE = 4'h4;
    localparam logic [3:0] RSI_OFS_CLEAR = 4'h8;
    localparam logic [3:0] RSI_OFS_CTRL = 4'hC;
    // control register bits
    localparam int RSI_CTRL_SOFT = 0;
    localparam int RSI_CTRL_SEL = 1;
    localparam int RSI_CTRL_ACK = 2;
    // action vector bits
    localparam int RSI_ACT_EEPROM = 0;
    localparam int RSI_ACT_UCODE = 1;
    localparam int RSI_ACT_MAC = 2;
    localparam int RSI_ACT_PTRS = 3;
    localparam int RSI_ACT_CFGREG = 4;
    localparam int RSI_ACT_PHY = 5;
    localparam int RSI_ACT_PME = 6;
    localparam int RSI_ACT_STATS = 7;
    localparam int RSI_ACT_PINS = 8;
    localparam int RSI_ACT_MGMT_KILL = 9;
    localparam int RSI_ACT_MGMT_ABORT = 10;
    localparam int RSI_ACT_REPORT = 11;
    localparam int RSI_ACT_W = 12;
    // source index, precedence order; event status uses the same layout
    localparam int RSI_SRC_POR = 0;
    localparam int RSI_SRC_ALT = 1;
    localparam int RSI_SRC_BUS = 2;
    localparam int RSI_SRC_ISO = 3;
    localparam int RSI_SRC_D3D0 = 4;
    localparam int RSI_SRC_SOFT = 5;
    localparam int RSI_SRC_SEL = 6;
    localparam int RSI_SRC_N = 7;
    localparam logic [RSI_SRC_N-1:0] RSI_STATUS_RST = 7'h01;
    localparam logic [1:0] RSI_PS_D3 = 2'h3;
    localparam logic [1:0] RSI_PS_D0 = 2'h0;
    typedef enum logic [1:0] {
        RSI_MG_IDLE = 2'b00,
        RSI_MG_READ = 2'b01,
        RSI_MG_WRITE = 2'b10,
        RSI_MG_ZERO = 2'b11
    } rsi_mg_e;
endpackage

// ===== verilog/rsi_top.sv
// reset source ranking, initialization fan-out and management-bus abort control
`timescale 1ns/1ns
module rsi_top (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // reset sources
    input wire logic por_i,
    input wire logic alternate_reset_n_i,
    input wire logic bus_reset_n_i,
    input wire logic bus_n_a_i,
    input wire logic [1:0] power_state_i,
    input wire logic aux_power_select_pin_i,
    input wire logic [7:0] cfg_pins_i,
    // management controller transaction side
    input wire logic mg_read_start_i,
    input wire logic mg_write_start_i,
    input wire logic mg_cycle_end_i,
    input wire logic [7:0] mg_rd_data_i,
    input wire logic mg_wr_valid_i,
    input wire logic mg_status_set_i,
    input wire logic mg_rx_en_set_i,
    // management outputs
    output logic [7:0] mg_rd_data_o,
    output logic mg_wr_commit_o,
    output logic mg_status_o,
    output logic mg_rx_en_o,
    output logic mg_init_bit_o,
    output logic mgmt_alert_n_o,
    output logic mgmt_alert_n_oe_n_o,
    // init actions
    output logic [11:0] init_act_o,
    output logic [7:0] cfg_latched_o,
    output logic pme_state_o,
    // avalon-mm slave
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic irq_o
);
    logic alt_q_r, bus_q_r, iso_q_r, por_q_r;
    logic [1:0] ps_q_r;
    logic [6:0] src;
    logic [11:0] act_nxt;
    logic [6:0] status_r, enable_r;
    logic soft_pulse, sel_pulse, ack_pulse;
    logic alert_pend_r;
    rsi_pkg::rsi_mg_e mg_st_r;

    // edge history; reset values idle so nothing fires on release
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            alt_q_r <= 1'b1;
            bus_q_r <= 1'b1;
            iso_q_r <= 1'b1;
            por_q_r <= 1'b0;
            ps_q_r <= rsi_pkg::RSI_PS_D0;
        end else begin
            alt_q_r <= alternate_reset_n_i;
            bus_q_r <= bus_reset_n_i;
            iso_q_r <= bus_n_a_i;
            por_q_r <= por_i;
            ps_q_r <= power_state_i;
        end
    end

    // software commands arrive as register writes
    assign soft_pulse = avs_write && !avs_waitrequest && avs_address == rsi_pkg::RSI_OFS_CTRL
        && avs_writedata[rsi_pkg::RSI_CTRL_SOFT];
    assign sel_pulse = avs_write && !avs_waitrequest && avs_address == rsi_pkg::RSI_OFS_CTRL
        && avs_writedata[rsi_pkg::RSI_CTRL_SEL];
    assign ack_pulse = avs_write && !avs_waitrequest && avs_address == rsi_pkg::RSI_OFS_CTRL
        && avs_writedata[rsi_pkg::RSI_CTRL_ACK];

    // source events, in precedence order
    always_comb begin
        src = '0;
        src[rsi_pkg::RSI_SRC_POR] = por_q_r && !por_i;
        src[rsi_pkg::RSI_SRC_ALT] = !alt_q_r && alternate_reset_n_i;
        // bus reset acts on release; in d3 explicitly so
        src[rsi_pkg::RSI_SRC_BUS] = !bus_q_r && bus_reset_n_i;
        src[rsi_pkg::RSI_SRC_ISO] = !iso_q_r && bus_n_a_i;
        src[rsi_pkg::RSI_SRC_D3D0] = ps_q_r == rsi_pkg::RSI_PS_D3
            && power_state_i == rsi_pkg::RSI_PS_D0;
        src[rsi_pkg::RSI_SRC_SOFT] = soft_pulse;
        src[rsi_pkg::RSI_SRC_SEL] = sel_pulse;
    end

    // OR of every active source's effects
    always_comb begin
        logic hard;
        logic wide;
        hard = src[rsi_pkg::RSI_SRC_POR] | src[rsi_pkg::RSI_SRC_ALT]
            | src[rsi_pkg::RSI_SRC_BUS];
        wide = hard | src[rsi_pkg::RSI_SRC_ISO];
        act_nxt = '0;
        act_nxt[rsi_pkg::RSI_ACT_EEPROM] = wide;
        act_nxt[rsi_pkg::RSI_ACT_UCODE] = wide | src[rsi_pkg::RSI_SRC_D3D0]
            | src[rsi_pkg::RSI_SRC_SOFT];
        act_nxt[rsi_pkg::RSI_ACT_MAC] = act_nxt[rsi_pkg::RSI_ACT_UCODE];
        act_nxt[rsi_pkg::RSI_ACT_PTRS] = |src;
        act_nxt[rsi_pkg::RSI_ACT_CFGREG] = wide | src[rsi_pkg::RSI_SRC_D3D0];
        act_nxt[rsi_pkg::RSI_ACT_PHY] = hard;
        act_nxt[rsi_pkg::RSI_ACT_PME] = src[rsi_pkg::RSI_SRC_POR] | src[rsi_pkg::RSI_SRC_ALT]
            | ((src[rsi_pkg::RSI_SRC_BUS] | src[rsi_pkg::RSI_SRC_ISO])
            & !aux_power_select_pin_i);
        act_nxt[rsi_pkg::RSI_ACT_STATS] = |src;
        act_nxt[rsi_pkg::RSI_ACT_PINS] = hard;
        act_nxt[rsi_pkg::RSI_ACT_MGMT_KILL] = wide;
        act_nxt[rsi_pkg::RSI_ACT_MGMT_ABORT] = src[rsi_pkg::RSI_SRC_D3D0]
            | src[rsi_pkg::RSI_SRC_SOFT] | src[rsi_pkg::RSI_SRC_SEL];
        act_nxt[rsi_pkg::RSI_ACT_REPORT] = act_nxt[rsi_pkg::RSI_ACT_MGMT_ABORT];
    end

    // one-cycle action strobes
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            init_act_o <= '0;
        end else begin
            init_act_o <= act_nxt;
        end
    end

    // configuration straps captured on qualifying sources only
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            cfg_latched_o <= 8'h00;
        end else if (act_nxt[rsi_pkg::RSI_ACT_PINS]) begin
            cfg_latched_o <= cfg_pins_i;
        end
    end

    // wake event state; set here when mgmt status and rx enable set strobes coincide, clear wins
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            pme_state_o <= 1'b0;
        end else if (act_nxt[rsi_pkg::RSI_ACT_PME]) begin
            pme_state_o <= 1'b0;
        end else if (mg_status_set_i && mg_rx_en_set_i) begin
            pme_state_o <= 1'b1;
        end
    end

    // management transaction tracker
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mg_st_r <= rsi_pkg::RSI_MG_IDLE;
        end else if (act_nxt[rsi_pkg::RSI_ACT_MGMT_KILL]) begin
            mg_st_r <= rsi_pkg::RSI_MG_IDLE;
        end else begin
            case (mg_st_r)
                rsi_pkg::RSI_MG_IDLE: begin
                    if (mg_read_start_i) begin
                        mg_st_r <= rsi_pkg::RSI_MG_READ;
                    end else if (mg_write_start_i) begin
                        mg_st_r <= rsi_pkg::RSI_MG_WRITE;
                    end
                end
                rsi_pkg::RSI_MG_READ: begin
                    if (mg_cycle_end_i) begin
                        mg_st_r <= rsi_pkg::RSI_MG_IDLE;
                    end else if (act_nxt[rsi_pkg::RSI_ACT_MGMT_ABORT]) begin
                        mg_st_r <= rsi_pkg::RSI_MG_ZERO;
                    end
                end
                // aborted write parks in zero state too: no commits until end
                rsi_pkg::RSI_MG_WRITE: begin
                    if (mg_cycle_end_i) begin
                        mg_st_r <= rsi_pkg::RSI_MG_IDLE;
                    end else if (act_nxt[rsi_pkg::RSI_ACT_MGMT_ABORT]) begin
                        mg_st_r <= rsi_pkg::RSI_MG_ZERO;
                    end
                end
                rsi_pkg::RSI_MG_ZERO: begin
                    if (mg_cycle_end_i) begin
                        mg_st_r <= rsi_pkg::RSI_MG_IDLE;
                    end
                end
                default: mg_st_r <= rsi_pkg::RSI_MG_IDLE;
            endcase
        end
    end

    // read data forced to zero once aborted
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mg_rd_data_o <= 8'h00;
            mg_wr_commit_o <= 1'b0;
        end else begin
            mg_rd_data_o <= (mg_st_r == rsi_pkg::RSI_MG_READ
                && !act_nxt[rsi_pkg::RSI_ACT_MGMT_ABORT]
                && !act_nxt[rsi_pkg::RSI_ACT_MGMT_KILL]) ? mg_rd_data_i : 8'h00;
            mg_wr_commit_o <= mg_st_r == rsi_pkg::RSI_MG_WRITE && mg_wr_valid_i
                && !act_nxt[rsi_pkg::RSI_ACT_MGMT_ABORT]
                && !act_nxt[rsi_pkg::RSI_ACT_MGMT_KILL];
        end
    end

    // status and receive enable: hard sources and bus_n_a force inactive, others keep
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mg_status_o <= 1'b0;
            mg_rx_en_o <= 1'b0;
        end else if (act_nxt[rsi_pkg::RSI_ACT_MGMT_KILL]) begin
            mg_status_o <= 1'b0;
            mg_rx_en_o <= 1'b0;
        end else if (!act_nxt[rsi_pkg::RSI_ACT_REPORT]) begin
            // frozen during the abort cycle
            mg_status_o <= mg_status_o | mg_status_set_i;
            mg_rx_en_o <= mg_rx_en_o | mg_rx_en_set_i;
        end
    end

    // init bit and alert held until mgmt ack; new report wins over ack
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mg_init_bit_o <= 1'b0;
            alert_pend_r <= 1'b0;
        end else if (act_nxt[rsi_pkg::RSI_ACT_REPORT]) begin
            mg_init_bit_o <= 1'b1;
            alert_pend_r <= 1'b1;
        end else if (ack_pulse) begin
            mg_init_bit_o <= 1'b0;
            alert_pend_r <= 1'b0;
        end
    end

    // open drain: level always low, enable low means driving
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            mgmt_alert_n_o <= 1'b0;
            mgmt_alert_n_oe_n_o <= 1'b1;
        end else begin
            mgmt_alert_n_o <= 1'b0;
            mgmt_alert_n_oe_n_o <= !(alert_pend_r || act_nxt[rsi_pkg::RSI_ACT_REPORT]);
        end
    end

    // sticky event status, set wins over clear
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            status_r <= rsi_pkg::RSI_STATUS_RST;
        end else if (avs_write && !avs_waitrequest && avs_address == rsi_pkg::RSI_OFS_CLEAR) begin
            status_r <= (status_r & ~avs_writedata[6:0]) | src;
        end else begin
            status_r <= status_r | src;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            enable_r <= 7'h00;
        end else if (avs_write && !avs_waitrequest && avs_address == rsi_pkg::RSI_OFS_ENABLE) begin
            enable_r <= avs_writedata[6:0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |((status_r | src) & enable_r);
        end
    end

    // one wait state per access: waitrequest drops the cycle after a request
    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
            if (avs_read && avs_waitrequest) begin
                case (avs_address)
                    rsi_pkg::RSI_OFS_STATUS: avs_readdata <= {25'h0, status_r};
                    rsi_pkg::RSI_OFS_ENABLE: avs_readdata <= {25'h0, enable_r};
                    rsi_pkg::RSI_OFS_CTRL: avs_readdata <= {29'h0, mg_init_bit_o,
                        mg_rx_en_o, mg_status_o};
                    default: avs_readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

// ===== bench/rsi_assertions.sv
// checker for the reset source and initialization control block
`timescale 1ns/1ns
module rsi_assertions (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_i,
    // watched inputs
    input wire logic bus_n_a_i,
    input wire logic [7:0] cfg_pins_i,
    // watched outputs
    input wire logic [11:0] init_act_o,
    input wire logic [7:0] cfg_latched_o,
    input wire logic [7:0] mg_rd_data_o,
    input wire logic mg_wr_commit_o,
    input wire logic mg_status_o,
    input wire logic mg_rx_en_o,
    input wire logic mg_init_bit_o,
    input wire logic mgmt_alert_n_o,
    input wire logic mgmt_alert_n_oe_n_o
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    iso_release_a: assert property ($rose(bus_n_a_i) |-> ##[1:3] init_act_o[0])
        else $error("bus_n_a release without eeprom load");
    soft_scope_a: assert property (init_act_o[2] |-> init_act_o[1] && init_act_o[3] && init_act_o[7])
        else $error("mac reset without wider set");
    strap_sample_a: assert property (init_act_o[8] |-> ##[0:2] cfg_latched_o == cfg_pins_i)
        else $error("straps not latched");
    mgmt_kill_a: assert property (init_act_o[9] |-> ##[0:1] !mg_status_o && !mg_rx_en_o)
        else $error("status or rx enable left active");
    read_zero_a: assert property (init_act_o[10] |-> (mg_rd_data_o == 8'h00) [*6])
        else $error("aborted read returned data");
    write_block_a: assert property (init_act_o[10] |-> !mg_wr_commit_o [*6])
        else $error("aborted write committed");
    init_report_a: assert property (init_act_o[11] |-> ##[0:1] !mgmt_alert_n_oe_n_o && mg_init_bit_o)
        else $error("no alert or init bit");
    alert_od_a: assert property (!mgmt_alert_n_o)
        else $error("alert drives high");
endmodule
bind rsi_top rsi_assertions u_chk (.ref_clk_i, .rst_i, .bus_n_a_i, .cfg_pins_i, .init_act_o,
    .cfg_latched_o, .mg_rd_data_o, .mg_wr_commit_o, .mg_status_o, .mg_rx_en_o, .mg_init_bit_o,
    .mgmt_alert_n_o, .mgmt_alert_n_oe_n_o);

// ===== bench/rsi_mgmt_partner.sv
// management controller model: one read or write cycle of fixed length
`timescale 1ns/1ns
module rsi_mgmt_partner #(
    parameter int LEN = 12
) (
    // clock and commands
    input wire logic ref_clk_i,
    input wire logic go_rd_i,
    input wire logic go_wr_i,
    // toward the design
    output logic rd_start_o = 1'b0,
    output logic wr_start_o = 1'b0,
    output logic end_o = 1'b0,
    output logic [7:0] data_o,
    output logic wr_valid_o,
    output logic busy_o = 1'b0
);
    int cnt = 0;
    logic wr_r = 1'b0;
    logic [6:0] pat_r = 7'h00;
    // data changes every cycle and is never zero, so a zero is the design's doing
    assign data_o = {1'b1, pat_r};
    assign wr_valid_o = busy_o & wr_r;
    always @(posedge ref_clk_i) begin
        pat_r <= pat_r + 7'h01;
        rd_start_o <= go_rd_i & !busy_o;
        wr_start_o <= go_wr_i & !busy_o;
        end_o <= busy_o && cnt == 1;
        if (!busy_o && (go_rd_i || go_wr_i)) begin
            busy_o <= 1'b1;
            cnt <= LEN;
            wr_r <= go_wr_i;
        end else if (busy_o) begin
            cnt <= cnt - 1;
            busy_o <= cnt != 1;
        end
    end
endmodule

// ===== bench/test_reset_source_init_control.sv
// bench for the reset source and initialization control block
`timescale 1ns/1ns
module test_reset_source_init_control;
    logic ref_clk_i = 1'b0, rst_i = 1'b1, por_i = 1'b0, alternate_reset_n_i = 1'b1;
    logic bus_reset_n_i = 1'b1, bus_n_a_i = 1'b1, aux_power_select_pin_i = 1'b0;
    logic mg_status_set_i = 1'b0, mg_rx_en_set_i = 1'b0, go_rd = 1'b0, go_wr = 1'b0;
    logic avs_read = 1'b0, avs_write = 1'b0, p_busy;
    logic [1:0] power_state_i = 2'h0;
    logic [3:0] avs_address = 4'h0;
    logic [7:0] cfg_pins_i = 8'h00, mg_rd_data_i, mg_rd_data_o, cfg_latched_o;
    logic [31:0] avs_writedata = 32'h0, avs_readdata;
    logic mg_read_start_i, mg_write_start_i, mg_cycle_end_i, mg_wr_valid_i, mg_wr_commit_o;
    logic mg_status_o, mg_rx_en_o, mg_init_bit_o, mgmt_alert_n_o, mgmt_alert_n_oe_n_o;
    logic pme_state_o, avs_waitrequest, irq_o;
    logic [11:0] init_act_o;
    // pulled-up alert line: only the low drive is real
    wire alert_w = mgmt_alert_n_oe_n_o ? 1'b1 : mgmt_alert_n_o;
    int miscompares = 0, n_tests = 0, cycles = 0, commits = 0, c0;
    // expected actions per source; bits outside the mask are left to the design
    localparam logic [11:0] EXP [7] = '{12'h1FF, 12'h3FF, 12'h3FF, 12'h2DF, 12'hC9E, 12'hC8E, 12'hC88};
    localparam logic [11:0] MSK [7] = '{12'h1FF, 12'h3FF, 12'h3FF, 12'h3FF, 12'hDFF, 12'hFFF, 12'hFFF};
    rsi_top DUT (.*);
    rsi_mgmt_partner #(.LEN(12)) u_mgmt (.ref_clk_i(ref_clk_i), .go_rd_i(go_rd), .go_wr_i(go_wr),
        .rd_start_o(mg_read_start_i), .wr_start_o(mg_write_start_i), .end_o(mg_cycle_end_i),
        .data_o(mg_rd_data_i), .wr_valid_o(mg_wr_valid_i), .busy_o(p_busy));
    initial forever #20 ref_clk_i = ~ref_clk_i;
    always @(negedge ref_clk_i) begin
        cycles++;
        commits += int'(mg_wr_commit_o === 1'b1);
        if (cycles == 6000) begin
            miscompares++;
            summarize();
        end
    end
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one avalon transfer; request held until waitrequest is seen low at an edge
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        @(posedge ref_clk_i);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge ref_clk_i);
        end while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(q, e, "read");
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    // hold a pin or power source active (no action allowed) and release it, or write the soft/selective bit; expect the action pulse
    task automatic fire(input int s, input logic [11:0] e, input logic [11:0] m);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        cfg_pins_i <= 8'(17 * (s + 1));
        if (s >= 5) wr(4'hC, 32'(1 << (s - 5)));
        else begin
            por_i <= s == 0;
            alternate_reset_n_i <= s != 1;
            bus_reset_n_i <= s != 2;
            bus_n_a_i <= s != 3;
            power_state_i <= (s == 4) ? rsi_pkg::RSI_PS_D3 : rsi_pkg::RSI_PS_D0;
            repeat (4) begin
                @(negedge ref_clk_i);
                chk(init_act_o, 12'h0, "early action");
            end
            @(posedge ref_clk_i);
            por_i <= 1'b0;
            alternate_reset_n_i <= 1'b1;
            bus_reset_n_i <= 1'b1;
            bus_n_a_i <= 1'b1;
            power_state_i <= rsi_pkg::RSI_PS_D0;
        end
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (init_act_o === 12'h0 && n < 8);
        chk(init_act_o & m, e & m, "actions");
    endtask
    task automatic flags();
        @(posedge ref_clk_i);
        mg_status_set_i <= 1'b1;
        mg_rx_en_set_i <= 1'b1;
        @(posedge ref_clk_i);
        mg_status_set_i <= 1'b0;
        mg_rx_en_set_i <= 1'b0;
        @(negedge ref_clk_i);
    endtask
    initial begin
        repeat (20) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        rd(4'h0, 32'h01);
        rd(4'h2, 32'h0);
        wr(4'h8, 32'h7F);
        wr(4'h4, 32'h7F);
        rd(4'h4, 32'h7F);
        $display("test registers done");
        for (int s = 0; s < 7; s++) begin
            fire(s, EXP[s], MSK[s]);
            rd(4'h0, 32'(1 << s));
            rd(4'hC, s >= 4 ? 32'h4 : 32'h0);
            @(negedge ref_clk_i);
            chk(irq_o, 1'b1, "irq");
            chk(cfg_latched_o, s <= 2 ? 8'(17 * (s + 1)) : 8'h33, "straps");
            chk(alert_w, s < 4, "alert");
            wr(4'h8, 32'(1 << s));
            wr(4'hC, 32'h4);
            // alert enable is a register behind the pending flag: two edges
            repeat (2) @(negedge ref_clk_i);
            chk(irq_o, 1'b0, "irq clear");
            chk(alert_w, 1'b1, "alert ack");
        end
        $display("test sources done");
        flags();
        aux_power_select_pin_i <= 1'b1;
        fire(2, 12'h3BF, 12'h3FF);
        chk(pme_state_o, 1'b1, "pme kept");
        flags();
        go_rd <= 1'b1;
        @(posedge ref_clk_i);
        go_rd <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        chk(mg_rd_data_o & 8'h80, 8'h80, "read data");
        fire(5, 12'hC8E, 12'hFFF);
        @(negedge ref_clk_i);
        chk(mg_rd_data_o, 8'h00, "aborted read");
        rd(4'hC, 32'h7);
        repeat (12) @(negedge ref_clk_i);
        go_wr <= 1'b1;
        @(posedge ref_clk_i);
        go_wr <= 1'b0;
        repeat (4) @(negedge ref_clk_i);
        chk(commits > 0, 1'b1, "write lands");
        fire(6, 12'hC88, 12'hFFF);
        c0 = commits;
        repeat (14) @(negedge ref_clk_i);
        chk(commits, c0, "aborted write");
        wr(4'hC, 32'h4);
        fire(1, 12'h3FF, 12'h3FF);
        rd(4'hC, 32'h0);
        @(negedge ref_clk_i);
        chk(pme_state_o, 1'b0, "pme cleared");
        $display("test management done");
        summarize();
    end
endmodule
